// ==== tb/dra_bus_model.sv ====
// Partner model: bus clock sampling pulses, CPU accesses and DMA transfer completion
`timescale 1ns/1ps
`default_nettype none
module dra_bus_model (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Ownership seen and pacing choice
    input  wire logic dma_owns,
    input  wire logic cpu_owns,
    input  wire logic slow,
    // Bus timing pulses
    output var  logic bclk_fall,
    output var  logic cpu_access_done,
    output var  logic xfer_done
);
    logic [3:0] div_reg;
    logic [3:0] acc_reg;
    logic [3:0] xfr_reg;
    // Bus clock falling edge every fourth cycle
    always_ff @(posedge aclk) begin
        div_reg   <= aresetn ? div_reg + 4'h1 : 4'h0;
        bclk_fall <= aresetn && div_reg[1:0] == 2'h3;
    end
    // CPU needs three cycles of ownership before it ends one access
    always_ff @(posedge aclk) begin
        acc_reg         <= (aresetn && cpu_owns) ? acc_reg + 4'h1 : 4'h0;
        cpu_access_done <= aresetn && cpu_owns && acc_reg == 4'h2;
    end
    // One unit moved per grant; slow pacing stretches the transfer
    always_ff @(posedge aclk) begin
        xfr_reg   <= (aresetn && dma_owns) ? xfr_reg + 4'h1 : 4'h0;
        xfer_done <= aresetn && dma_owns && xfr_reg == (slow ? 4'h6 : 4'h1);
    end
endmodule : dra_bus_model
`default_nettype wire

// ==== tb/dra_top_asserts.sv ====
// Checker: bus ownership and register handshake properties of the request arbiter
`timescale 1ns/1ps
`default_nettype none
module dra_top_asserts (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus answers
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Bus timing and ownership
    input wire logic        bclk_fall,
    input wire logic        cpu_access_done,
    input wire logic        xfer_done,
    input wire logic        channel_zero_grant,
    input wire logic        channel_one_grant,
    input wire logic        cpu_grant
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic owed_reg;
    // CPU is owed one access after every DMA transfer; a grant before it would starve the CPU
    always_ff @(posedge aclk) begin
        if (!aresetn)
            owed_reg <= 1'h0;
        else if ($rose(cpu_grant))
            owed_reg <= 1'h1;
        else if (cpu_access_done)
            owed_reg <= 1'h0;
    end
    chk_owner_one_hot: assert property ($onehot({channel_zero_grant, channel_one_grant, cpu_grant}))
        else $error("bus owner is not one-hot");
    chk_grant_on_sample: assert property ($fell(cpu_grant) |-> $past(bclk_fall, 2))
        else $error("DMA grant not tied to a sampling edge");
    chk_zero_returns_cpu: assert property (channel_zero_grant && xfer_done |-> ##2 cpu_grant)
        else $error("bus not back to CPU after channel zero");
    chk_one_returns_cpu: assert property (channel_one_grant && xfer_done |-> ##2 cpu_grant)
        else $error("bus not back to CPU after channel one");
    chk_cpu_access_between: assert property ($rose(channel_zero_grant) || $rose(channel_one_grant) |-> !owed_reg)
        else $error("DMA grant before the CPU finished an access");
    chk_grant_held: assert property ((channel_zero_grant || channel_one_grant) && !xfer_done && !$past(xfer_done)
        |=> $stable({channel_zero_grant, channel_one_grant}))
        else $error("DMA grant changed before transfer end");
    chk_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
endmodule : dra_top_asserts
bind dra_top dra_top_asserts u_dra_asserts (
    .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .bclk_fall(bclk_fall), .cpu_access_done(cpu_access_done),
    .xfer_done(xfer_done), .channel_zero_grant(channel_zero_grant),
    .channel_one_grant(channel_one_grant), .cpu_grant(cpu_grant)
);
`default_nettype wire

// ==== tb/dra_top_tb.sv ====
// Testbench: request latching, arbitration order and interrupt of the request arbiter
`timescale 1ns/1ps
`default_nettype none
module dra_top_tb
    import dra_pkg::*;
;
    logic        aclk    = 1'h0;
    logic        aresetn = 1'h0;
    logic        slow    = 1'h0;
    logic        awvalid = 1'h0;
    logic        wvalid  = 1'h0;
    logic        bready  = 1'h0;
    logic        arvalid = 1'h0;
    logic        rready  = 1'h0;
    logic [7:0]  awaddr  = 8'h00;
    logic [7:0]  araddr  = 8'h00;
    logic [31:0] wdata   = 32'h0;
    logic [31:0] irqs    = 32'h0;
    logic        awready, wready, bvalid, arready, rvalid, bclk_fall, cpu_done, xfer_done, g0, g1, gc, irq;
    logic [1:0]  bresp, rresp;
    logic [1:0]  own_prev;
    logic [31:0] rdata;
    logic [1:0]  log_q[$];
    int          err_count    = 0;
    int          total_checks = 0;
    always #20 aclk = ~aclk;
    dra_top #(.NSRC(32)) dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_flag_bit(irqs),
        .bclk_fall(bclk_fall), .cpu_access_done(cpu_done), .xfer_done(xfer_done),
        .channel_zero_grant(g0), .channel_one_grant(g1), .cpu_grant(gc), .irq(irq)
    );
    dra_bus_model u_model (
        .aclk(aclk), .aresetn(aresetn), .dma_owns(g0 | g1), .cpu_owns(gc), .slow(slow),
        .bclk_fall(bclk_fall), .cpu_access_done(cpu_done), .xfer_done(xfer_done)
    );
    // Owner history, one entry per change, so order is judged after the fact
    always @(posedge aclk) begin
        if ({g1, g0} != own_prev) log_q.push_back({g1, g0});
        own_prev <= {g1, g0};
    end
    //--------------------------------------------------------------------------
    // Shared tasks
    //--------------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        for (int n = 0; n < 60 && !bvalid; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end
        bready <= 1'h0;
        chk({31'h0, bvalid}, 32'h1);
        chk({30'h0, bresp}, {30'h0, er});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        for (int n = 0; n < 60 && !rvalid; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end
        rready <= 1'h0;
        chk({31'h0, rvalid}, 32'h1);
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
    endtask : rd
    // Bounded wait for a number of owner changes
    task automatic wait_log(input int n);
        for (int i = 0; i < 400 && log_q.size() < n; i++) @(posedge aclk);
        repeat (20) @(posedge aclk);
    endtask : wait_log
    //--------------------------------------------------------------------------
    // Scenarios
    //--------------------------------------------------------------------------
    task automatic t_regs;
        rd(OWNER_OFF, 32'h0, RESP_OKAY);
        rd(CTL0_OFF, 32'h0, RESP_OKAY);
        wr(OWNER_OFF, 32'h1, RESP_SLVERR);
        rd(8'h1C, 32'h0, RESP_SLVERR);
        chk({31'h0, gc}, 32'h1);
        $display("Test registers done");
    endtask : t_regs
    // Flags in both banks rise together, one per channel, in one sampling period
    task automatic t_both;
        logic [1:0] seq [4];
        seq = '{OWN_CH0, OWN_CPU, OWN_CH1, OWN_CPU};
        slow <= 1'h1;
        wr(SEL0_OFF, 32'h3, RESP_OKAY);
        wr(SEL1_OFF, 32'h13, RESP_OKAY);
        rd(SEL1_OFF, 32'h13, RESP_OKAY);
        wr(CTL0_OFF, 32'h2, RESP_OKAY);
        wr(CTL1_OFF, 32'h2, RESP_OKAY);
        wr(IRQ_MSK_OFF, 32'h3, RESP_OKAY);
        log_q.delete();
        irqs <= 32'h0008_0008;
        wait_log(4);
        chk(log_q.size(), 32'h4);
        foreach (seq[i]) chk({30'h0, log_q[i]}, {30'h0, seq[i]});
        rd(IRQ_STS_OFF, 32'h3, RESP_OKAY);
        chk({31'h0, irq}, 32'h1);
        wr(IRQ_STS_OFF, 32'h1, RESP_OKAY);
        rd(IRQ_STS_OFF, 32'h2, RESP_OKAY);
        chk({31'h0, irq}, 32'h1);
        wr(IRQ_MSK_OFF, 32'h1, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        wr(IRQ_STS_OFF, 32'h2, RESP_OKAY);
        rd(IRQ_STS_OFF, 32'h0, RESP_OKAY);
        $display("Test both channels done");
    endtask : t_both
    // Repeated software requests while disabled collapse into one transfer
    task automatic t_collapse;
        slow  <= 1'h0;
        irqs  <= 32'h0;
        wr(SEL0_OFF, 32'h0, RESP_OKAY);
        wr(CTL0_OFF, 32'h0, RESP_OKAY);
        repeat (3) wr(SEL0_OFF, 32'h20, RESP_OKAY);
        repeat (8) @(posedge aclk);
        rd(CTL0_OFF, 32'h1, RESP_OKAY);
        rd(OWNER_OFF, 32'h0, RESP_OKAY);
        log_q.delete();
        wr(CTL0_OFF, 32'h3, RESP_OKAY);
        wait_log(2);
        chk(log_q.size(), 32'h2);
        chk({30'h0, log_q[0]}, {30'h0, OWN_CH0});
        rd(CTL0_OFF, 32'h2, RESP_OKAY);
        wr(SEL1_OFF, 32'h0, RESP_OKAY);
        wr(CTL1_OFF, 32'h0, RESP_OKAY);
        wr(SEL1_OFF, 32'h20, RESP_OKAY);
        repeat (8) @(posedge aclk);
        rd(CTL1_OFF, 32'h1, RESP_OKAY);
        wr(CTL1_OFF, 32'h0, RESP_OKAY);
        rd(CTL1_OFF, 32'h0, RESP_OKAY);
        $display("Test collapse and clear done");
    endtask : t_collapse
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test
    // Watchdog well beyond the few hundred cycles the scenarios need
    initial begin
        #(40 * 20000);
        err_count++;
        finish_test();
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        t_regs();
        t_both();
        t_collapse();
        finish_test();
    end
endmodule : dra_top_tb
`default_nettype wire

// ==== verilog/dra_arbiter.sv ====
// Module: bus arbiter among channel zero, channel one and the CPU
`timescale 1ns/1ps
`default_nettype none
module dra_arbiter
    import dra_pkg::*;
(
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Bus sampling and handshakes
    input  wire logic bclk_fall,
    input  wire logic cpu_access_done,
    input  wire logic xfer_done,
    // Core side
    dra_if.arb        ifc
);
    // ------------------------------------------------------------
    // Ownership state machine
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_CPU  = 2'b00,
        ST_CH0  = 2'b01,
        ST_CH1  = 2'b10,
        ST_HAND = 2'b11
    } dra_arb_st_t;
    dra_arb_st_t st_reg;
    logic        cpu_turn_reg;   // CPU owes one access before next channel

    // Grant only at sampling points, channel zero first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg       <= ST_CPU;
            cpu_turn_reg <= 1'b0;
        end else begin
            case (st_reg)
                ST_CPU: begin
                    if (cpu_access_done)
                        cpu_turn_reg <= 1'b0;
                    if (bclk_fall && (!cpu_turn_reg || cpu_access_done)) begin
                        if (ifc.pend[0] && ifc.enable[0])
                            st_reg <= ST_CH0;
                        else if (ifc.pend[1] && ifc.enable[1])
                            st_reg <= ST_CH1;
                    end
                end
                ST_CH0, ST_CH1: begin
                    if (xfer_done) begin
                        st_reg       <= ST_CPU;
                        cpu_turn_reg <= 1'b1;
                    end
                end
                default: st_reg <= ST_CPU;
            endcase
        end
    end

    // Grant pulse and done pulse generation
    logic [1:0] grant_reg;
    logic [1:0] done_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            grant_reg <= 2'b00;
            done_reg  <= 2'b00;
        end else begin
            grant_reg[0] <= (st_reg == ST_CPU) && bclk_fall && (!cpu_turn_reg || cpu_access_done)
                            && ifc.pend[0] && ifc.enable[0];
            grant_reg[1] <= (st_reg == ST_CPU) && bclk_fall && (!cpu_turn_reg || cpu_access_done)
                            && !(ifc.pend[0] && ifc.enable[0]) && ifc.pend[1] && ifc.enable[1];
            done_reg[0]  <= (st_reg == ST_CH0) && xfer_done;
            done_reg[1]  <= (st_reg == ST_CH1) && xfer_done;
        end
    end

    assign ifc.grant = grant_reg;
    assign ifc.done  = done_reg;
    assign ifc.owner = st_reg;
endmodule : dra_arbiter
`default_nettype wire

// ==== verilog/dra_if.sv ====
// Interface: pending-flag, enable, grant, done and owner handoff between arbiter core and its register front end
`timescale 1ns/1ps
`default_nettype none
interface dra_if;
    logic [1:0] pend;      // Request pending flags
    logic [1:0] enable;    // Channel enable bits
    logic [1:0] grant;     // Pulse: channel won the bus
    logic [1:0] done;      // Pulse: channel transfer complete
    logic [1:0] owner;     // Current bus owner code
    modport regs (output enable, input pend, grant, done, owner);
    modport arb  (input enable, pend, output grant, done, owner);
endinterface : dra_if
`default_nettype wire

// ==== verilog/dra_pkg.sv ====
// Package: register map, field layout, responses and owner encoding of the request arbiter
package dra_pkg;
    // Register byte offsets (AXI4-Lite, one aligned word each)
    localparam logic [7:0] SEL0_OFF    = 8'h00;  // Channel zero source select
    localparam logic [7:0] SEL1_OFF    = 8'h04;  // Channel one source select
    localparam logic [7:0] CTL0_OFF    = 8'h08;  // Channel zero control
    localparam logic [7:0] CTL1_OFF    = 8'h0C;  // Channel one control
    localparam logic [7:0] IRQ_STS_OFF = 8'h10;  // Sticky event status
    localparam logic [7:0] IRQ_MSK_OFF = 8'h14;  // Event mask
    localparam logic [7:0] OWNER_OFF   = 8'h18;  // Current bus owner
    // Source select fields
    localparam int SRC_LSB  = 0;  // Source code field, 4 bits
    localparam int SRC_W    = 4;
    localparam int BANK_BIT = 4;  // Source bank select
    localparam int SWREQ_BIT = 5; // Software request bit
    localparam logic [4:0] SRC_SOFT = 5'h00;  // Bank 0, code 0 = software trigger
    // Control fields
    localparam int PEND_BIT = 0;  // Request pending flag
    localparam int EN_BIT   = 1;  // Channel enable bit
    // Status bits: done events per channel
    localparam int DONE0_BIT = 0;
    localparam int DONE1_BIT = 1;
    localparam int NUM_SRC   = 32;  // Peripheral request lines (bank:code)
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Bus owner encoding
    typedef enum logic [1:0] {
        OWN_CPU  = 2'b00,
        OWN_CH0  = 2'b01,
        OWN_CH1  = 2'b10
    } dra_owner_t;
endpackage : dra_pkg

// ==== verilog/dra_top.sv ====
// Module: request latching, AXI4-Lite registers and interrupt for two DMA channels
`timescale 1ns/1ps
`default_nettype none
module dra_top
    import dra_pkg::*;
#(
    parameter int NSRC = NUM_SRC
) (
    // Clock and reset
    input  wire logic            aclk,
    input  wire logic            aresetn,
    // AXI4-Lite write address
    input  wire logic [7:0]      s_axi_awaddr,
    input  wire logic            s_axi_awvalid,
    output var  logic            s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]     s_axi_wdata,
    input  wire logic [3:0]      s_axi_wstrb,
    input  wire logic            s_axi_wvalid,
    output var  logic            s_axi_wready,
    // AXI4-Lite write response
    output var  logic [1:0]      s_axi_bresp,
    output var  logic            s_axi_bvalid,
    input  wire logic            s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]      s_axi_araddr,
    input  wire logic            s_axi_arvalid,
    output var  logic            s_axi_arready,
    // AXI4-Lite read data
    output var  logic [31:0]     s_axi_rdata,
    output var  logic [1:0]      s_axi_rresp,
    output var  logic            s_axi_rvalid,
    input  wire logic            s_axi_rready,
    // Peripheral request flags and bus timing
    input  wire logic [NSRC-1:0] irq_flag_bit,
    input  wire logic            bclk_fall,
    input  wire logic            cpu_access_done,
    input  wire logic            xfer_done,
    // Bus ownership and interrupt
    output var  logic            channel_zero_grant,
    output var  logic            channel_one_grant,
    output var  logic            cpu_grant,
    output var  logic            irq
);
    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    logic [5:0]  sel_reg [2];          // channel_source_select_reg per channel
    logic [1:0]  request_pending_flag;
    logic [1:0]  channel_enable_bit;
    logic [1:0]  req_seen_reg;         // Request caught in current sampling period
    logic [1:0]  irq_prev_reg;         // Selected flag last cycle, for edge detect
    logic [1:0]  sts_reg;
    logic [1:0]  msk_reg;
    logic [7:0]  wa_reg;
    logic [31:0] wd_reg;
    logic [3:0]  ws_reg;
    logic        wa_have_reg;
    logic        wd_have_reg;
    logic        wr_fire;
    logic [1:0]  sw_set;               // Software request this cycle
    logic [1:0]  irq_sel;              // Selected peripheral flag per channel

    dra_if ifc ();

    // Source index: bank bit above the code field
    function automatic logic [4:0] src_index(input logic [5:0] sel);
        src_index = sel[BANK_BIT:SRC_LSB];
    endfunction : src_index

    // Write hits a register offset with its low byte lane enabled
    function automatic logic hit(input logic [7:0] off);
        hit = wr_fire && (wa_reg == off) && ws_reg[0];
    endfunction : hit

    // ------------------------------------------------------------
    // AXI4-Lite write path: address and data taken in either order
    // ------------------------------------------------------------
    assign wr_fire = wa_have_reg && wd_have_reg && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wa_have_reg   <= 1'b0;
            wd_have_reg   <= 1'b0;
            wa_reg        <= 8'h00;
            wd_reg        <= 32'h0000_0000;
            ws_reg        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= !wa_have_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !wd_have_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                wa_have_reg <= 1'b1;
                wa_reg      <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wd_have_reg <= 1'b1;
                wd_reg      <= s_axi_wdata;
                ws_reg      <= s_axi_wstrb;
            end
            if (wr_fire) begin
                wa_have_reg  <= 1'b0;
                wd_have_reg  <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // Owner register is read-only; unmapped offsets answer with an error
                s_axi_bresp  <= (wa_reg <= IRQ_MSK_OFF && wa_reg[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Source select and enable; the software request bit is not stored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_reg[0]         <= 6'h00;
            sel_reg[1]         <= 6'h00;
            channel_enable_bit <= 2'b00;
            msk_reg            <= 2'b00;
        end else begin
            if (hit(SEL0_OFF)) sel_reg[0] <= {1'b0, wd_reg[BANK_BIT:SRC_LSB]};
            if (hit(SEL1_OFF)) sel_reg[1] <= {1'b0, wd_reg[BANK_BIT:SRC_LSB]};
            if (hit(CTL0_OFF)) channel_enable_bit[0] <= wd_reg[EN_BIT];
            if (hit(CTL1_OFF)) channel_enable_bit[1] <= wd_reg[EN_BIT];
            if (hit(IRQ_MSK_OFF)) msk_reg <= wd_reg[1:0];
        end
    end

    // Software request strobes, only under the software trigger source
    always_comb begin
        sw_set[0] = hit(SEL0_OFF) && wd_reg[SWREQ_BIT]
                    && wd_reg[BANK_BIT:SRC_LSB] == SRC_SOFT;
        sw_set[1] = hit(SEL1_OFF) && wd_reg[SWREQ_BIT]
                    && wd_reg[BANK_BIT:SRC_LSB] == SRC_SOFT;
    end

    // Selected peripheral flag per channel; bank 0 code 0 is software only
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            irq_sel[c] = (src_index(sel_reg[c]) != SRC_SOFT)
                         && irq_flag_bit[src_index(sel_reg[c])];
        end
    end

    // ------------------------------------------------------------
    // Request capture and pending flags
    // ------------------------------------------------------------
    // Requests gathered over the period, committed together at the falling edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_seen_reg <= 2'b00;
            irq_prev_reg <= 2'b00;
        end else begin
            irq_prev_reg <= irq_sel;
            for (int c = 0; c < 2; c++) begin
                if (bclk_fall)
                    req_seen_reg[c] <= sw_set[c] || (irq_sel[c] && !irq_prev_reg[c]);
                else if (sw_set[c] || (irq_sel[c] && !irq_prev_reg[c]))
                    req_seen_reg[c] <= 1'b1;
            end
        end
    end

    // Pending flag: set at sample point wins over the grant clear of the same edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            request_pending_flag <= 2'b00;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (bclk_fall && req_seen_reg[c])
                    request_pending_flag[c] <= 1'b1;
                else if (ifc.grant[c])
                    request_pending_flag[c] <= 1'b0;
                else if (hit(c == 0 ? CTL0_OFF : CTL1_OFF) && !wd_reg[PEND_BIT])
                    request_pending_flag[c] <= 1'b0;
            end
        end
    end

    assign ifc.pend   = request_pending_flag;
    assign ifc.enable = channel_enable_bit;

    // ------------------------------------------------------------
    // Arbiter
    // ------------------------------------------------------------
    dra_arbiter u_arb (
        .aclk            (aclk),
        .aresetn         (aresetn),
        .bclk_fall       (bclk_fall),
        .cpu_access_done (cpu_access_done),
        .xfer_done       (xfer_done),
        .ifc             (ifc.arb)
    );

    // ------------------------------------------------------------
    // Interrupt status and outputs
    // ------------------------------------------------------------
    // Done events set sticky bits; set wins over write-one-to-clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sts_reg <= 2'b00;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (ifc.done[c])
                    sts_reg[c] <= 1'b1;
                else if (hit(IRQ_STS_OFF) && wd_reg[c])
                    sts_reg[c] <= 1'b0;
            end
        end
    end

    // Registered ownership view; one cycle behind the arbiter state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            channel_zero_grant <= 1'b0;
            channel_one_grant  <= 1'b0;
            cpu_grant          <= 1'b1;
            irq                <= 1'b0;
        end else begin
            channel_zero_grant <= ifc.owner == OWN_CH0;
            channel_one_grant  <= ifc.owner == OWN_CH1;
            cpu_grant          <= ifc.owner == OWN_CPU;
            irq                <= |(sts_reg & msk_reg);
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= RESP_OKAY;
                s_axi_rdata  <= 32'h0000_0000;
                if (s_axi_araddr == SEL0_OFF)
                    s_axi_rdata[BANK_BIT:SRC_LSB] <= sel_reg[0][BANK_BIT:SRC_LSB];
                else if (s_axi_araddr == SEL1_OFF)
                    s_axi_rdata[BANK_BIT:SRC_LSB] <= sel_reg[1][BANK_BIT:SRC_LSB];
                else if (s_axi_araddr == CTL0_OFF)
                    s_axi_rdata[1:0] <= {channel_enable_bit[0], request_pending_flag[0]};
                else if (s_axi_araddr == CTL1_OFF)
                    s_axi_rdata[1:0] <= {channel_enable_bit[1], request_pending_flag[1]};
                else if (s_axi_araddr == IRQ_STS_OFF)
                    s_axi_rdata[1:0] <= sts_reg;
                else if (s_axi_araddr == IRQ_MSK_OFF)
                    s_axi_rdata[1:0] <= msk_reg;
                else if (s_axi_araddr == OWNER_OFF)
                    s_axi_rdata[1:0] <= ifc.owner;
                else
                    s_axi_rresp <= RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : dra_top
`default_nettype wire
